// >>> inc/rirq_pkg.sv
// Constants for the reader interrupt status logic.
// Assumes a 50 MHz system clock and 8-bit registers on a 32-bit bus.
package rirq_pkg;

    // Clock and collision window timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned COL_BIT_RATE_BPS = 106_000;
    localparam int unsigned COL_WIN_CYC = CLK_HZ / COL_BIT_RATE_BPS;

    // Register indices, byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h01;
    localparam logic [5:0] IDX_NRWAIT = 6'h07;
    localparam logic [5:0] IDX_STAT = 6'h0C;
    localparam logic [5:0] IDX_MASK = 6'h0D;
    localparam logic [5:0] IDX_COLPOS = 6'h0E;

    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] NRWAIT_RST = 8'h10;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h3E;
    localparam logic [7:0] COLPOS_RST = 8'h00;

    // Status flag positions
    localparam int unsigned ST_TX = 7;
    localparam int unsigned ST_RX = 6;
    localparam int unsigned ST_FIFO = 5;
    localparam int unsigned ST_CRC = 4;
    localparam int unsigned ST_PAR = 3;
    localparam int unsigned ST_FRM = 2;
    localparam int unsigned ST_COL = 1;
    localparam int unsigned ST_NR = 0;

    // Protocol control fields
    localparam int unsigned CTRL_NO_RX_CRC = 7;
    localparam int unsigned CTRL_COL7 = 6;
    localparam logic [1:0] PROTO_14443A = 2'h1;
    localparam logic [1:0] PROTO_15693 = 2'h2;

    // FIFO and collision thresholds
    localparam logic [3:0] FIFO_HIGH_LVL = 4'h8;
    localparam logic [3:0] FIFO_LOW_LVL = 4'h4;
    localparam logic [3:0] COL_THR_LO = 4'h6;
    localparam logic [3:0] COL_THR_HI = 4'h7;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// >>> src/rirq_status.sv
// Interrupt status, mask and collision position registers of a reader.
// Assumes framer event inputs synchronous to clk_i, AXI4-Lite host side.
//
// What this block does
// - Status clears on reset, enable low, control write
// - Status read clears flags and drops request
// - During transmit only flags 7 and 5 change
// - During receive only flag 6 changes, no request
// - Request raised only at end of phase or on no-response timeout
// - Transmit flag set at start, request at end
// - Receive flag set on start-of-frame, request at end
// - FIFO flag: over 8 receive, under 4 transmit
// - CRC fail flag only when CRC check enabled
// - Parity fail flag in 14443 A mode
// - Framing or end-of-frame fault in bit 2
// - Collision when events exceed 6 or 7 per bit
// - No-response flag after wait time, 15693 only
// - Mask register loads 0x3E on reset, enable low
// - Mask read clears collision bits, keeps enables
// - Mask layout: position 7:6, enables 5:0
// - Low collision position read-cleared at 0x0E
//
// The AXI4-Lite slave port was decided locally.
module rirq_status
    import rirq_pkg::*;
#(
    parameter int unsigned NR_STEP_CYC = 64
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // Framer events
    input wire logic tx_start_i,
    input wire logic tx_end_i,
    input wire logic rx_sof_i,
    input wire logic rx_end_i,
    input wire logic [3:0] fifo_level_i,
    input wire logic crc_err_i,
    input wire logic parity_err_i,
    input wire logic framing_err_i,
    input wire logic coll_evt_i,
    input wire logic [9:0] col_pos_i,
    // Host request and decoder control
    output logic irq_o,
    output logic decoder_en_o
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_full;
        logic w_full;
        logic [5:0] aw_idx;
        logic [7:0] w_data;
        logic w_low;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl;
        logic [7:0] nrwait;
        logic [7:0] stat;
        logic [7:0] mask;
        logic [7:0] colpos;
        logic [7:0] pend;
        logic irq;
        logic tx_busy;
        logic rx_busy;
        logic dec_en;
        logic [8:0] win_cnt;
        logic [3:0] evt_cnt;
        logic nr_armed;
        logic [15:0] nr_cnt;
    } rirq_state_t;

    localparam rirq_state_t ST_RESET = '{
        awready: 1'b1, wready: 1'b1, arready: 1'b1, dec_en: 1'b1,
        ctrl: CTRL_RST, nrwait: NRWAIT_RST, stat: STAT_RST,
        mask: MASK_RST, colpos: COLPOS_RST, default: '0};

    localparam logic [8:0] WIN_CYC = 9'(COL_WIN_CYC);
    localparam logic [15:0] NR_STEP = 16'(NR_STEP_CYC);

    rirq_state_t s_r;
    rirq_state_t s_nxt;
    logic [7:0] set_v;
    logic [7:0] pend_v;
    logic clr_stat;
    logic raise;
    logic nr_exp;
    logic capture;
    logic wr_go;
    logic ar_go;
    logic [5:0] ar_idx;

    // Register read mux shared by the read path
    function automatic logic [7:0] rd_mux(input rirq_state_t st,
                                          input logic [5:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            IDX_CTRL: v = st.ctrl;
            IDX_NRWAIT: v = st.nrwait;
            IDX_STAT: v = st.stat;
            IDX_MASK: v = st.mask;
            IDX_COLPOS: v = st.colpos;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic is_mapped(input logic [5:0] idx);
        return idx == IDX_CTRL || idx == IDX_NRWAIT || idx == IDX_STAT ||
               idx == IDX_MASK || idx == IDX_COLPOS;
    endfunction

    // Next-state logic: bus slave, phases, flags and request
    always_comb begin
        logic [3:0] thr;
        logic [3:0] evt_next;
        thr = 4'h0;
        evt_next = 4'h0;
        s_nxt = s_r;
        set_v = 8'h00;
        pend_v = 8'h00;
        clr_stat = 1'b0;
        raise = 1'b0;
        nr_exp = 1'b0;
        ar_idx = araddr_i[7:2];
        ar_go = arvalid_i && s_r.arready;
        wr_go = s_r.aw_full && s_r.w_full && !s_r.bvalid;

        // Write address and data taken in either order
        if (awvalid_i && s_r.awready) begin
            s_nxt.aw_full = 1'b1;
            s_nxt.aw_idx = awaddr_i[7:2];
        end
        if (wvalid_i && s_r.wready) begin
            s_nxt.w_full = 1'b1;
            s_nxt.w_data = wdata_i[7:0];
            s_nxt.w_low = wstrb_i[0];
        end
        if (s_r.bvalid && bready_i) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = is_mapped(s_r.aw_idx) ? RESP_OKAY : RESP_DECERR;
            if (s_r.w_low) begin
                unique case (s_r.aw_idx)
                    IDX_CTRL: begin
                        s_nxt.ctrl = s_r.w_data;
                        clr_stat = 1'b1;
                    end
                    IDX_NRWAIT: s_nxt.nrwait = s_r.w_data;
                    IDX_MASK: s_nxt.mask[5:0] = s_r.w_data[5:0];
                    default: ;
                endcase
            end
        end

        // Read: data latched and read side effects at address accept
        if (s_r.rvalid && rready_i) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ar_go) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = {24'h00_0000, rd_mux(s_r, ar_idx)};
            s_nxt.rresp = is_mapped(ar_idx) ? RESP_OKAY : RESP_DECERR;
            if (ar_idx == IDX_STAT) begin
                clr_stat = 1'b1;
            end
            if (ar_idx == IDX_MASK) begin
                s_nxt.mask[7:6] = 2'b00;
            end
            if (ar_idx == IDX_COLPOS) begin
                s_nxt.colpos = 8'h00;
            end
        end

        // Transmit phase: only transmit and FIFO flags move
        if (tx_start_i && !s_r.tx_busy) begin
            s_nxt.tx_busy = 1'b1;
            s_nxt.rx_busy = 1'b0;
            s_nxt.nr_armed = 1'b0;
            set_v[ST_TX] = 1'b1;
        end
        if (s_r.tx_busy && fifo_level_i < FIFO_LOW_LVL) begin
            set_v[ST_FIFO] = 1'b1;
        end

        // Receive phase: errors held back until the frame ends
        if (rx_sof_i && !s_r.tx_busy && !s_r.rx_busy) begin
            s_nxt.rx_busy = 1'b1;
            s_nxt.nr_armed = 1'b0;
            set_v[ST_RX] = 1'b1;
        end
        if (s_r.rx_busy) begin
            pend_v[ST_FIFO] = fifo_level_i > FIFO_HIGH_LVL;
            pend_v[ST_CRC] = crc_err_i && !s_r.ctrl[CTRL_NO_RX_CRC];
            pend_v[ST_PAR] = parity_err_i &&
                             s_r.ctrl[1:0] == PROTO_14443A;
            pend_v[ST_FRM] = framing_err_i;
        end

        // Collision events counted inside one 106 kbps bit window
        thr = s_r.ctrl[CTRL_COL7] ? COL_THR_HI : COL_THR_LO;
        if (s_r.win_cnt != 9'h000) begin
            s_nxt.win_cnt = s_r.win_cnt - 9'h001;
        end
        if (coll_evt_i && s_r.rx_busy) begin
            if (s_r.win_cnt == 9'h000) begin
                s_nxt.win_cnt = WIN_CYC;
                evt_next = 4'h1;
            end else begin
                evt_next = (s_r.evt_cnt == 4'hF) ? 4'hF :
                           s_r.evt_cnt + 4'h1;
            end
            s_nxt.evt_cnt = evt_next;
            pend_v[ST_COL] = evt_next > thr;
        end
        // A transmit that aborts a receive drops its held-back errors
        s_nxt.pend = s_nxt.rx_busy ? (s_r.pend | pend_v) : 8'h00;

        // Error position follows the latest collision or error
        capture = |pend_v[ST_COL +: 4];
        if (capture) begin
            s_nxt.colpos = col_pos_i[7:0];
            s_nxt.mask[7:6] = col_pos_i[9:8];
        end

        // Phase ends commit flags and may raise the request
        if (tx_end_i && s_r.tx_busy) begin
            s_nxt.tx_busy = 1'b0;
            s_nxt.nr_armed = s_r.ctrl[1:0] == PROTO_15693;
            s_nxt.nr_cnt = 16'h0000;
            raise = 1'b1;
        end
        if (rx_end_i && s_r.rx_busy) begin
            s_nxt.rx_busy = 1'b0;
            s_nxt.pend = 8'h00;
            set_v = set_v | s_r.pend | pend_v;
            raise = 1'b1;
        end
        if (raise) begin
            raise = |((s_r.stat | set_v) & {2'b11, s_r.mask[5:0]});
        end

        // No-response wait after a 15693 transmit
        if (s_r.nr_armed) begin
            s_nxt.nr_cnt = s_r.nr_cnt + 16'h0001;
            if ({8'h00, s_r.nrwait} * NR_STEP <= s_r.nr_cnt) begin
                nr_exp = !(rx_sof_i || tx_start_i);
            end
        end
        if (nr_exp) begin
            s_nxt.nr_armed = 1'b0;
            set_v[ST_NR] = 1'b1;
            raise = raise || s_r.mask[ST_NR];
        end

        // Set wins over clear for both flags and request
        s_nxt.stat = (clr_stat ? 8'h00 : s_r.stat) | set_v;
        s_nxt.irq = (s_r.irq && !clr_stat) || raise;
        s_nxt.dec_en = !s_nxt.tx_busy;

        // Enable pin low returns registers, phases and request to their reset state; bus channels keep theirs
        if (!en_i) begin
            s_nxt.ctrl = CTRL_RST;
            s_nxt.nrwait = NRWAIT_RST;
            s_nxt.stat = STAT_RST;
            s_nxt.mask = MASK_RST;
            s_nxt.colpos = COLPOS_RST;
            s_nxt.pend = 8'h00;
            s_nxt.irq = 1'b0;
            s_nxt.tx_busy = 1'b0;
            s_nxt.rx_busy = 1'b0;
            s_nxt.dec_en = 1'b1;
            s_nxt.win_cnt = 9'h000;
            s_nxt.evt_cnt = 4'h0;
            s_nxt.nr_armed = 1'b0;
        end

        s_nxt.awready = !s_nxt.aw_full;
        s_nxt.wready = !s_nxt.w_full;
        s_nxt.arready = !s_nxt.rvalid;
    end

    // State register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign awready_o = s_r.awready;
    assign wready_o = s_r.wready;
    assign bvalid_o = s_r.bvalid;
    assign bresp_o = s_r.bresp;
    assign arready_o = s_r.arready;
    assign rvalid_o = s_r.rvalid;
    assign rdata_o = s_r.rdata;
    assign rresp_o = s_r.rresp;
    assign irq_o = s_r.irq;
    assign decoder_en_o = s_r.dec_en;

    // Checks on flags and request
    property p_en_reset;
        @(posedge clk_i) disable iff (!arst_n_i)
        !en_i |=> s_r.stat == STAT_RST && !irq_o && s_r.mask == MASK_RST;
    endproperty
    a_en_reset: assert property (p_en_reset)
        else $error("enable low did not reset registers");

    property p_ctrl_wr_clear;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_go && s_r.w_low && s_r.aw_idx == IDX_CTRL && set_v == 8'h00
        |=> s_r.stat == 8'h00;
    endproperty
    a_ctrl_wr_clear: assert property (p_ctrl_wr_clear)
        else $error("control write did not clear status");

    property p_read_clear;
        @(posedge clk_i) disable iff (!arst_n_i)
        ar_go && ar_idx == IDX_STAT && set_v == 8'h00 && !raise
        |=> s_r.stat == 8'h00 && !irq_o && rdata_o[7:0] == $past(s_r.stat);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status read did not clear flags");

    property p_tx_frozen;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_r.tx_busy && en_i && !clr_stat
        |=> (s_r.stat & 8'h5F) == ($past(s_r.stat) & 8'h5F) &&
            decoder_en_o == $past(tx_end_i);
    endproperty
    a_tx_frozen: assert property (p_tx_frozen)
        else $error("flag moved during transmit");

    property p_rx_no_irq;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_r.rx_busy && !(rx_end_i || tx_start_i || s_r.nr_armed) && !irq_o
        |=> !irq_o;
    endproperty
    a_rx_no_irq: assert property (p_rx_no_irq)
        else $error("request raised inside receive");

    property p_irq_cause;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(irq_o) |-> $past(tx_end_i && s_r.tx_busy ||
                               rx_end_i && s_r.rx_busy || nr_exp);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("request raised outside a phase end");

    property p_tx_flag;
        @(posedge clk_i) disable iff (!arst_n_i)
        tx_start_i && !s_r.tx_busy && en_i ##1 !clr_stat && en_i
        ##1 tx_end_i && s_r.tx_busy && en_i && !clr_stat
        |=> s_r.stat[ST_TX] && irq_o;
    endproperty
    a_tx_flag: assert property (p_tx_flag)
        else $error("transmit flag or request missing");

    property p_rx_flag;
        @(posedge clk_i) disable iff (!arst_n_i)
        rx_sof_i && !s_r.tx_busy && !s_r.rx_busy && en_i && !irq_o
        && !s_r.nr_armed |=> s_r.stat[ST_RX] && !irq_o;
    endproperty
    a_rx_flag: assert property (p_rx_flag)
        else $error("receive flag wrong at start of frame");

    property p_mask_read;
        @(posedge clk_i) disable iff (!arst_n_i)
        ar_go && ar_idx == IDX_MASK && !capture && en_i && !wr_go
        |=> s_r.mask[7:6] == 2'b00 && s_r.mask[5:0] == $past(s_r.mask[5:0]);
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read handled wrongly");

    property p_crc_gate;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_r.rx_busy && s_r.ctrl[CTRL_NO_RX_CRC] && !s_r.pend[ST_CRC]
        && en_i && !rx_end_i |=> !s_r.pend[ST_CRC];
    endproperty
    a_crc_gate: assert property (p_crc_gate)
        else $error("CRC fail recorded while check disabled");

endmodule

// >>> tb/rirq_host.sv
// AXI4-Lite host model issuing one register access at a time.
// Assumes each task is entered just after a rising edge of clk_i.
module rirq_host (
    // Clock
    input wire logic clk_i,
    // Write channels
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    // Read channels
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
        {bready_o, araddr_o, arvalid_o, rready_o} = '0;
    end

    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr_o <= a;
        wdata_o <= d;
        wstrb_o <= 4'hf;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk_i);
            if (!ad && awready_i) begin
                ad = 1'b1;
                awvalid_o <= 1'b0;
                awaddr_o <= ~a;
            end
            if (!wd && wready_i) begin
                wd = 1'b1;
                wvalid_o <= 1'b0;
                wdata_o <= ~d;
            end
        end
        do @(posedge clk_i); while (!bvalid_i);
        r = bresp_i;
        // Ready left high: a back-to-back call never drives it twice
    endtask

    // Read held until taken, data taken at the answer edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do @(posedge clk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
        do @(posedge clk_i); while (!rvalid_i);
        d = rdata_i;
        r = rresp_i;
        // Ready left high: a back-to-back call never drives it twice
    endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the reader interrupt status block.
// Assumes rirq_host as bus master; framer events come from this bench.
module testbench;
    import rirq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [7:0] A_NRW = {IDX_NRWAIT, 2'b00};
    localparam logic [7:0] A_STAT = {IDX_STAT, 2'b00};
    localparam logic [7:0] A_MASK = {IDX_MASK, 2'b00};
    localparam logic [7:0] A_COLP = {IDX_COLPOS, 2'b00};

    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic en_i = 1'b1;
    logic [7:0] evt = 8'h00;
    logic [3:0] fifo = 4'h6;
    logic [9:0] cpos = 10'h000;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, dec_en;
    logic [31:0] seed = 32'hf298;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int m_exp;
    logic [1:0] wr_resp;

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    rirq_status #(.NR_STEP_CYC(2)) dut_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .en_i(en_i),
        .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
        .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
        .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
        .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
        .rvalid_o(rvalid), .rready_i(rready),
        .tx_start_i(evt[0]), .tx_end_i(evt[1]), .rx_sof_i(evt[2]),
        .rx_end_i(evt[3]), .fifo_level_i(fifo), .crc_err_i(evt[4]),
        .parity_err_i(evt[5]), .framing_err_i(evt[6]),
        .coll_evt_i(evt[7]), .col_pos_i(cpos), .irq_o(irq),
        .decoder_en_o(dec_en)
    );

    rirq_host host_u (
        .clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
        .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
        .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
        .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready)
    );

    // Xorshift source of random stimulus
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic final_report;
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Value comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register read compared with the expected data and response
    task automatic rdc(input logic [7:0] a, input int e,
                       input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        host_u.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // Register write with junk in the unused upper bits
    task automatic wrc(input logic [7:0] a, input logic [7:0] v);
        logic [1:0] r;
        seed = xs(seed);
        host_u.wr(a, {seed[31:8], v}, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    // One-cycle framer pulses, then one idle cycle
    task automatic pulse(input logic [7:0] m);
        evt <= m;
        @(posedge clk_i);
        evt <= 8'h00;
        @(posedge clk_i);
    endtask

    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        // Reset values, map and read-only mask bits
        rdc(A_STAT, 0, RESP_OKAY);
        rdc(A_MASK, 'h3e, RESP_OKAY);
        rdc(A_COLP, 0, RESP_OKAY);
        rdc(8'h3c, 0, RESP_DECERR);
        host_u.wr(8'h3c, 32'h0000_00ff, wr_resp);
        chk({30'h0, wr_resp}, {30'h0, RESP_DECERR});
        wrc(A_MASK, 8'hff);
        rdc(A_MASK, 'h3f, RESP_OKAY);
        // Transmit: only flags 7 and 5 move, request at the end
        pulse(8'h01);
        chk(dec_en, 0);
        seed = xs(seed);
        fifo <= {2'b00, seed[1:0]};
        pulse(8'h74);
        fifo <= 4'h6;
        chk(irq, 0);
        pulse(8'h02);
        chk(irq, 1);
        chk(dec_en, 1);
        rdc(A_STAT, 'ha0, RESP_OKAY);
        chk(irq, 0);
        rdc(A_STAT, 0, RESP_OKAY);
        // Control write clears pending flags
        pulse(8'h01);
        pulse(8'h02);
        wrc(A_CTRL, PROTO_14443A);
        chk(irq, 0);
        rdc(A_STAT, 0, RESP_OKAY);
        // Receive errors with and without checking enabled
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            cpos <= seed[9:0];
            fifo <= 4'h9 + {1'b0, seed[12:10]} % 4'h7;
            pulse(8'h04);
            chk(irq, 0);
            pulse(8'h70);
            fifo <= 4'h6;
            pulse(8'h08);
            chk(irq, 1);
            m_exp = (i == 0) ? 'h7c : 'h64;
            rdc(A_STAT, m_exp, RESP_OKAY);
            rdc(A_COLP, cpos[7:0], RESP_OKAY);
            rdc(A_MASK, {cpos[9:8], 6'h3f}, RESP_OKAY);
            rdc(A_MASK, 'h3f, RESP_OKAY);
            rdc(A_COLP, 0, RESP_OKAY);
            wrc(A_CTRL, 8'h80);
        end
        // Collision thresholds of 6 and 7 events per bit
        for (int t = 0; t < 2; t++) begin
            wrc(A_CTRL, t ? 8'h40 : 8'h00);
            for (int n = 6 + t; n < 8 + t; n++) begin
                repeat (500) @(posedge clk_i);
                pulse(8'h04);
                repeat (n) pulse(8'h80);
                pulse(8'h08);
                m_exp = (n > 6 + t) ? 'h42 : 'h40;
                rdc(A_STAT, m_exp, RESP_OKAY);
            end
        end
        // Enable low resets status, mask and position
        pulse(8'h01);
        en_i <= 1'b0;
        @(posedge clk_i);
        en_i <= 1'b1;
        @(posedge clk_i);
        chk(dec_en, 1);
        rdc(A_STAT, 0, RESP_OKAY);
        rdc(A_MASK, 'h3e, RESP_OKAY);
        rdc(A_COLP, 0, RESP_OKAY);
        // No-response timeout, masked and per protocol
        wrc(A_NRW, 8'h10);
        for (int i = 0; i < 3; i++) begin
            wrc(A_CTRL, (i == 2) ? PROTO_14443A : PROTO_15693);
            wrc(A_MASK, (i == 1) ? 8'h3f : 8'h3e);
            pulse(8'h01);
            pulse(8'h02);
            rdc(A_STAT, 'h80, RESP_OKAY);
            repeat (40) @(posedge clk_i);
            chk(irq, (i == 1));
            rdc(A_STAT, (i == 2) ? 0 : 1, RESP_OKAY);
        end
        final_report();
    end
endmodule
